// ===== rtl/flash_ctrl_regs.svh
`ifndef FLASH_CTRL_REGS_SVH
`define FLASH_CTRL_REGS_SVH
// ----------------------------------------
// addresses
// ----------------------------------------
`define FC_ADDR_ONE   16'h0128
`define FC_ADDR_TWO   16'h012a
`define FC_ADDR_THREE 16'h012c
`define FC_ADDR_IE    16'h0000
// ----------------------------------------
// password byte
// ----------------------------------------
`define FC_KEY_WRITE  8'ha5
`define FC_KEY_READ   8'h96
// ----------------------------------------
// field positions
// ----------------------------------------
`define FC1_BLK       7
`define FC1_WRT       6
`define FC1_MASS_ERASE_SEL     2
`define FC1_ERASE     1
`define FC2_SRC_MSB   7
`define FC2_SRC_LSB   6
`define FC2_DIV_MSB   5
`define FC3_EMERGENCY_EXIT      5
`define FC3_LOCK      4
`define FC3_WAIT      3
`define FC3_ACCV      2
`define FC3_KEY_VIOLATION_FLAG      1
`define FC3_BUSY      0
`define IE_ACCESS_VIOLATION_IRQ_EN     5
// ----------------------------------------
// reset values
// ----------------------------------------
`define FC2_SRC_RESET 2'h1
`define FC2_DIV_RESET 6'h02
`define FC3_LOCK_RESET 1'h1
`define FC3_WAIT_RESET 1'h1
`endif

// ===== rtl/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
    // ----------------------------------------
    // erase cycle and clock source encodings
    // ----------------------------------------
    typedef enum logic [1:0] {
        ERASE_NONE    = 2'h0,
        ERASE_SEGMENT = 2'h1,
        ERASE_MAIN    = 2'h2,
        ERASE_ALL     = 2'h3
    } erase_mode_t;
    typedef enum logic [1:0] {
        SRC_AUX  = 2'h0,
        SRC_MAIN = 2'h1,
        SRC_SUB  = 2'h2,
        SRC_SUB2 = 2'h3
    } clk_src_t;
endpackage

// ===== rtl/flash_ctrl_register_interface.sv
`include "flash_ctrl_regs.svh"
module flash_ctrl_register_interface (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wrData,
    input  wire logic        wrEn,
    input  wire logic        rdEn,
    input  wire logic        tgBusy,
    input  wire logic        tgWaitReady,
    input  wire logic        accessViolation,
    input  wire logic        auxClkPin,
    input  wire logic        mainClkPin,
    input  wire logic        subClkPin,
    output logic      [15:0] rdData,
    output logic             writeSel,
    output logic             blockWriteSel,
    output flash_ctrl_pkg::erase_mode_t eraseMode,
    output logic             lockActive,
    output logic             emergencyExit,
    output logic             flashClkTick,
    output logic             powerUpClearReset,
    output logic             accessViolationIrq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [1:0] flashClkSrcSel;
    logic [5:0] flashClkDiv;
    logic [5:0] divCount;
    logic       waitBit;
    logic       accessViolationFlag;
    logic       keyViolationFlag;
    logic       accessViolationIrqEn;
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic [2:0] syncC;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire selOne   = addr == `FC_ADDR_ONE;
    wire selTwo   = addr == `FC_ADDR_TWO;
    wire selThree = addr == `FC_ADDR_THREE;
    wire selIe    = addr == `FC_ADDR_IE;
    wire selAny   = selOne | selTwo | selThree;
    wire wrGo     = ce & wrEn;
    wire keyOk    = wrData[15:8] == `FC_KEY_WRITE;
    wire keyBad   = wrGo & selAny & ~keyOk;
    wire wrOne    = wrGo & selOne & keyOk;
    wire wrTwo    = wrGo & selTwo & keyOk;
    wire wrThree  = wrGo & selThree & keyOk;
    wire wrIe     = wrGo & selIe;
    wire blockMode = blockWriteSel & writeSel;
    wire violOne  = wrOne & ((tgBusy & ~blockMode)
                    | (blockMode & ~waitBit));
    wire violTwo  = wrTwo & tgBusy;
    wire takeOne  = wrOne & ~violOne;
    wire takeTwo  = wrTwo & ~violTwo;
    wire accvSet  = violOne | violTwo | accessViolation;
    wire emexNow  = wrThree ? wrData[`FC3_EMERGENCY_EXIT]
                            : emergencyExit;
    wire lockRise = wrThree & wrData[`FC3_LOCK] & ~lockActive;
    wire blkEnd   = lockRise & blockWriteSel & waitBit;

    // ----------------------------------------
    // next values
    // ----------------------------------------
    wire next_accv = accvSet
                   | (wrThree ? wrData[`FC3_ACCV]
                              : accessViolationFlag);
    wire next_key_violation_flag = keyBad
                   | (wrThree ? wrData[`FC3_KEY_VIOLATION_FLAG]
                              : keyViolationFlag);
    wire next_wait = blkEnd ? 1'h0 : tgWaitReady;

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire [7:0] lowOne   = {blockWriteSel, writeSel, 3'h0,
                           eraseMode, 1'h0};
    wire [7:0] lowTwo   = {flashClkSrcSel, flashClkDiv};
    wire [7:0] lowThree = {2'h0, emergencyExit, lockActive,
                           waitBit, accessViolationFlag,
                           keyViolationFlag, tgBusy};
    wire [7:0] lowIe    = {2'h0, accessViolationIrqEn, 5'h00};
    wire [7:0] lowSel   = selOne   ? lowOne
                        : selTwo   ? lowTwo
                        : selThree ? lowThree
                        : selIe    ? lowIe
                        : 8'h00;
    wire [7:0] highSel  = selAny ? `FC_KEY_READ : 8'h00;

    assign accessViolationIrq = accessViolationFlag
                              & accessViolationIrqEn;

    // ----------------------------------------
    // mode register
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            blockWriteSel <= 1'h0;
            writeSel      <= 1'h0;
            eraseMode     <= flash_ctrl_pkg::ERASE_NONE;
        end else if (ce) begin
            if (emexNow) begin
                blockWriteSel <= 1'h0;
                writeSel      <= 1'h0;
                eraseMode     <= flash_ctrl_pkg::ERASE_NONE;
            end else if (takeOne) begin
                blockWriteSel <= wrData[`FC1_BLK];
                writeSel      <= wrData[`FC1_WRT];
                eraseMode     <= flash_ctrl_pkg::erase_mode_t'(
                    wrData[`FC1_MASS_ERASE_SEL:`FC1_ERASE]);
            end else if (blkEnd) begin
                blockWriteSel <= 1'h0;
            end
        end
    end

    // ----------------------------------------
    // clock control register
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flashClkSrcSel <= `FC2_SRC_RESET;
            flashClkDiv    <= `FC2_DIV_RESET;
        end else if (ce && takeTwo) begin
            flashClkSrcSel <= wrData[`FC2_SRC_MSB:`FC2_SRC_LSB];
            flashClkDiv    <= wrData[`FC2_DIV_MSB:0];
        end
    end

    // ----------------------------------------
    // status register
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            emergencyExit       <= 1'h0;
            lockActive          <= `FC3_LOCK_RESET;
            waitBit             <= `FC3_WAIT_RESET;
            accessViolationFlag <= 1'h0;
            keyViolationFlag    <= 1'h0;
            powerUpClearReset   <= 1'h0;
        end else if (ce) begin
            if (wrThree) begin
                emergencyExit <= wrData[`FC3_EMERGENCY_EXIT];
                lockActive    <= wrData[`FC3_LOCK];
            end
            waitBit             <= next_wait;
            accessViolationFlag <= next_accv;
            keyViolationFlag    <= next_key_violation_flag;
            powerUpClearReset   <= keyBad;
        end
    end

    // ----------------------------------------
    // shared interrupt enable
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            accessViolationIrqEn <= 1'h0;
        end else if (ce && wrIe) begin
            accessViolationIrqEn <= wrData[`IE_ACCESS_VIOLATION_IRQ_EN];
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdData <= 16'h0000;
        end else if (ce && rdEn) begin
            rdData <= {highSel, lowSel};
        end
    end

    // ----------------------------------------
    // clock pin synchronisers
    // ----------------------------------------
    wire [2:0] clkPins = {subClkPin, mainClkPin, auxClkPin};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    syncA[gi] <= 1'h0;
                    syncB[gi] <= 1'h0;
                    syncC[gi] <= 1'h0;
                end else if (ce) begin
                    syncA[gi] <= clkPins[gi];
                    syncB[gi] <= syncA[gi];
                    syncC[gi] <= syncB[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // flash clock divider
    // ----------------------------------------
    wire [1:0] srcIdx  = flashClkSrcSel[1] ? 2'h2
                       : flashClkSrcSel;
    wire       srcEdge = syncB[srcIdx] & ~syncC[srcIdx];
    wire       divDone = divCount == flashClkDiv;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            divCount     <= 6'h00;
            flashClkTick <= 1'h0;
        end else if (ce) begin
            if (takeTwo) begin
                divCount     <= 6'h00;
                flashClkTick <= 1'h0;
            end else if (srcEdge) begin
                divCount     <= divDone ? 6'h00 : divCount + 6'h01;
                flashClkTick <= divDone;
            end else begin
                flashClkTick <= 1'h0;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence badWrite;
        ce && wrEn && selAny && !keyOk;
    endsequence

    sequence lockDuringBlock;
        ce && lockRise && blockWriteSel && waitBit;
    endsequence

    emergency_exit_clears_wrt_a: assert property (
        ce && emergencyExit && !wrThree |=> !writeSel && !blockWriteSel)
        else $error("write select not cleared by exit");
    emergency_exit_clears_erase_a: assert property (
        ce && emexNow |=> eraseMode == flash_ctrl_pkg::ERASE_NONE)
        else $error("erase bits not cleared by exit");
    reserved_zero_a: assert property (
        ce && rdEn && selOne |=> rdData[5:3] == 3'h0 && !rdData[0])
        else $error("reserved bits read nonzero");
    read_key_a: assert property (
        ce && rdEn && selAny |=> rdData[15:8] == `FC_KEY_READ)
        else $error("upper byte not read key");
    key_viol_a: assert property (
        badWrite |=> keyViolationFlag && powerUpClearReset)
        else $error("bad password not flagged");
    one_viol_a: assert property (
        ce && wrOne && tgBusy && !blockMode && !emexNow
        |=> accessViolationFlag && $stable(eraseMode))
        else $error("control one write while busy not flagged");
    two_viol_a: assert property (
        ce && wrTwo && tgBusy
        |=> accessViolationFlag && $stable(flashClkDiv))
        else $error("clock write while busy not flagged");
    irq_gate_a: assert property (
        ce && accvSet && accessViolationIrqEn && !wrIe
        |=> accessViolationIrq)
        else $error("enabled violation gave no request");
    lock_block_a: assert property (
        lockDuringBlock |=> !blockWriteSel && !waitBit && lockActive)
        else $error("lock did not end block write");
    div_restart_a: assert property (
        ce && takeTwo |=> divCount == 6'h00 && !flashClkTick)
        else $error("divider not restarted");
    busy_read_a: assert property (
        ce && rdEn && selThree |=> rdData[0] == $past(tgBusy))
        else $error("busy bit does not mirror generator");
    reserved_three_a: assert property (
        ce && rdEn && selThree |=> rdData[7:6] == 2'h0)
        else $error("status reserved bits read nonzero");
    wait_follow_a: assert property (
        ce && !blkEnd |=> waitBit == $past(tgWaitReady))
        else $error("wait bit does not follow generator");
endmodule

// ===== testbench/flash_ctrl_register_interface_test.sv
`include "flash_ctrl_regs.svh"
module flash_ctrl_register_interface_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic                        clk_sys = 1'b0;
    logic                        rst;
    logic                        ce;
    logic [15:0]                 addr;
    logic [15:0]                 wrData;
    logic                        wrEn;
    logic                        rdEn;
    logic                        tgBusy;
    logic                        tgWaitReady;
    logic                        accessViolation;
    logic [4:0]                  pinCnt = 5'h00;
    logic [15:0]                 rdData;
    logic                        writeSel;
    logic                        blockWriteSel;
    flash_ctrl_pkg::erase_mode_t eraseMode;
    logic                        lockActive;
    logic                        emergencyExit;
    logic                        flashClkTick;
    logic                        powerUpClearReset;
    logic                        accessViolationIrq;
    logic [7:0]                  lowByte;
    int                          fails = 0;
    int                          check_count = 0;
    int                          tickCnt = 0;
    int                          pucCnt = 0;
    int                          start;
    // ----------------------------------------
    // design
    // ----------------------------------------
    flash_ctrl_register_interface dut_u (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .addr(addr),
        .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .tgBusy(tgBusy),
        .tgWaitReady(tgWaitReady), .accessViolation(accessViolation),
        .auxClkPin(pinCnt[3]), .mainClkPin(pinCnt[2]),
        .subClkPin(pinCnt[4]), .rdData(rdData), .writeSel(writeSel),
        .blockWriteSel(blockWriteSel), .eraseMode(eraseMode),
        .lockActive(lockActive), .emergencyExit(emergencyExit),
        .flashClkTick(flashClkTick), .powerUpClearReset(powerUpClearReset),
        .accessViolationIrq(accessViolationIrq)
    );
    // ----------------------------------------
    // clock, source pins, event counters
    // ----------------------------------------
    initial forever #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        pinCnt <= #2 pinCnt + 5'h01;
        if (flashClkTick === 1'b1) tickCnt++;
        if (powerUpClearReset === 1'b1) pucCnt++;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        addr = a;
        wrData = d;
        wrEn = 1'b1;
        cyc(1);
        wrEn = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [15:0] a);
        addr = a;
        rdEn = 1'b1;
        cyc(1);
        rdEn = 1'b0;
        cyc(1);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic logic [15:0] expOne(input logic [7:0] b);
        return {`FC_KEY_READ, b & 8'hc6};
    endfunction
    function automatic int expTicks(input int src, input int div);
        int period;
        period = (src == 0) ? 16 : (src == 1) ? 8 : 32;
        return 320 / period / (div + 1);
    endfunction
    function automatic int nearTo(input int got, input int exp);
        return (got >= exp - 1 && got <= exp + 1) ? exp : got;
    endfunction
    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    initial begin
        #1000000;
        fails++;
        end_sim;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        addr = 16'h0000;
        wrData = 16'h0000;
        wrEn = 1'b0;
        rdEn = 1'b0;
        tgBusy = 1'b0;
        tgWaitReady = 1'b1;
        accessViolation = 1'b0;
        void'($urandom(32'h6cd611c0));
        cyc(16);
        rst = 1'b0;
        check(16'(lockActive), 16'h0001);
        rd(`FC_ADDR_ONE);
        check(rdData, 16'h9600);
        rd(`FC_ADDR_TWO);
        check(rdData, 16'h9642);
        rd(`FC_ADDR_THREE);
        check(rdData, 16'h9618);
        rd(16'h0200);
        check(rdData, 16'h0000);
        for (int i = 0; i < 12; i++) begin
            lowByte = 8'($urandom);
            if (i < 4) lowByte[2:1] = 2'(i);
            wr(`FC_ADDR_ONE, {`FC_KEY_WRITE, lowByte});
            check(16'(writeSel), 16'(lowByte[6]));
            check(16'(blockWriteSel), 16'(lowByte[7]));
            check(16'(eraseMode), 16'(lowByte[2:1]));
            rd(`FC_ADDR_ONE);
            check(rdData, expOne(lowByte));
            lowByte = 8'($urandom);
            wr(`FC_ADDR_TWO, {`FC_KEY_WRITE, lowByte});
            rd(`FC_ADDR_TWO);
            check(rdData, {8'h96, lowByte});
        end
        wr(`FC_ADDR_ONE, 16'ha5c6);
        wr(`FC_ADDR_THREE, 16'ha530);
        check(16'(emergencyExit), 16'h0001);
        check(16'({writeSel, blockWriteSel}), 16'h0000);
        check(16'(eraseMode), 16'h0000);
        rd(`FC_ADDR_ONE);
        check(rdData, 16'h9600);
        wr(`FC_ADDR_THREE, 16'ha510);
        check(16'(emergencyExit), 16'h0000);
        wr(`FC_ADDR_THREE, 16'h0000);
        cyc(2);
        check(16'(pucCnt), 16'h0001);
        check(16'(lockActive), 16'h0001);
        rd(`FC_ADDR_THREE);
        check(16'(rdData[1]), 16'h0001);
        wr(`FC_ADDR_THREE, 16'ha510);
        rd(`FC_ADDR_THREE);
        check(16'(rdData[1]), 16'h0000);
        wr(`FC_ADDR_THREE, 16'ha500);
        check(16'(lockActive), 16'h0000);
        wr(`FC_ADDR_ONE, 16'ha5c0);
        cyc(2);
        rd(`FC_ADDR_THREE);
        check(rdData, 16'h9608);
        wr(`FC_ADDR_THREE, 16'ha510);
        check(16'(blockWriteSel), 16'h0000);
        tgWaitReady = 1'b0;
        cyc(2);
        rd(`FC_ADDR_THREE);
        check(rdData, 16'h9610);
        wr(`FC_ADDR_ONE, 16'ha500);
        tgBusy = 1'b1;
        wr(`FC_ADDR_ONE, 16'ha540);
        check(16'(writeSel), 16'h0000);
        rd(`FC_ADDR_THREE);
        check(rdData, 16'h9615);
        wr(`FC_ADDR_THREE, 16'ha510);
        wr(`FC_ADDR_TWO, {`FC_KEY_WRITE, ~lowByte});
        rd(`FC_ADDR_TWO);
        check(rdData, {8'h96, lowByte});
        rd(`FC_ADDR_THREE);
        check(16'(rdData[2]), 16'h0001);
        tgBusy = 1'b0;
        wr(`FC_ADDR_IE, 16'h0020);
        check(16'(accessViolationIrq), 16'h0001);
        wr(`FC_ADDR_IE, 16'h00df);
        check(16'(accessViolationIrq), 16'h0000);
        wr(`FC_ADDR_THREE, 16'ha510);
        rd(`FC_ADDR_THREE);
        check(16'(rdData[2]), 16'h0000);
        accessViolation = 1'b1;
        cyc(1);
        accessViolation = 1'b0;
        cyc(1);
        rd(`FC_ADDR_THREE);
        check(16'(rdData[2]), 16'h0001);
        wr(`FC_ADDR_IE, 16'h0020);
        check(16'(accessViolationIrq), 16'h0001);
        wr(`FC_ADDR_THREE, 16'ha510);
        check(16'(accessViolationIrq), 16'h0000);
        accessViolation = 1'b1;
        cyc(1);
        accessViolation = 1'b0;
        cyc(1);
        check(16'(accessViolationIrq), 16'h0001);
        wr(`FC_ADDR_ONE, 16'ha5c0);
        wr(`FC_ADDR_ONE, 16'ha500);
        check(16'(writeSel), 16'h0001);
        tgWaitReady = 1'b1;
        cyc(2);
        ce = 1'b0;
        wr(`FC_ADDR_ONE, 16'ha500);
        check(16'(writeSel), 16'h0001);
        ce = 1'b1;
        wr(`FC_ADDR_ONE, 16'ha500);
        check(16'(writeSel), 16'h0000);
        for (int s = 0; s < 4; s++) begin
            lowByte = {2'(s), 6'($urandom % 2)};
            wr(`FC_ADDR_TWO, {`FC_KEY_WRITE, lowByte});
            start = tickCnt;
            cyc(320);
            check(16'(nearTo(tickCnt - start, expTicks(s, lowByte[0]))),
                  16'(expTicks(s, lowByte[0])));
        end
        end_sim;
    end
endmodule
